/* src/pes_top.sv */
// event status, global interrupt control and page select registers
// assumes a classic wishbone master on the core clock; events are same-clock pulses,
// the shared power-down pin comes from outside and is synchronised here
`timescale 1ns/1ps
`include "pes_consts.svh"
module pes_top (
  input  wire logic                  i_core_clk,   // 20 MHz core clock
  input  wire logic                  i_sys_rst,    // synchronous reset, high
  input  wire logic                  i_wb_cyc,     // wishbone cycle
  input  wire logic                  i_wb_stb,     // wishbone strobe
  input  wire logic                  i_wb_we,      // wishbone write
  input  wire logic [`PES_ADR_W-1:0] i_wb_adr,     // byte address
  input  wire logic [3:0]            i_wb_sel,     // byte lanes
  input  wire logic [31:0]           i_wb_dat,     // write data
  output logic      [31:0]           o_wb_dat,     // read data
  output logic                       o_wb_ack,     // acknowledge
  input  wire pes_pkg::pes_evt_t     i_evt,        // event pulses, 7 quality .. 0 rx error
  output logic                       o_irq,        // interrupt level, high
  input  wire logic                  i_pd_pin,     // shared pin level in
  output logic                       o_pd_pin,     // shared pin drive value
  output logic                       o_pd_pin_oe,  // shared pin drive enable
  output logic                       o_powerdown,  // power-down request from pin
  output logic [`PES_PAGE_W-1:0]     o_page_sel,   // current register page
  output logic                       o_page_ext,   // extended page mapped
  output logic                       o_page_diag   // diagnostics page mapped
);
  pes_evt_if evt_bus ();

  pes_pkg::pes_bus_state_t st;
  pes_pkg::pes_bus_state_t next_st;
  pes_pkg::pes_evt_t       enable;
  pes_pkg::pes_evt_t       next_enable;
  logic [2:0]              ctrl;
  logic [2:0]              next_ctrl;
  logic [`PES_PAGE_W-1:0]  page;
  logic [`PES_PAGE_W-1:0]  next_page;
  logic [31:0]             rdat;
  logic [31:0]             next_rdat;
  logic                    take;
  logic                    irq_lvl;
  logic                    pin_meta;
  logic                    pin_sync;

  // decode of a register index against the byte address
  function automatic logic reg_hit(input logic [`PES_ADR_W-1:0] adr, input logic [5:0] idx);
    reg_hit = (adr == {idx, 2'b00});
  endfunction

  // a request is taken once; the ack follows one cycle later
  assign take = i_wb_cyc & i_wb_stb & (st == pes_pkg::PES_IDLE);

  // bus handshake state
  always_comb begin
    case (st)
      pes_pkg::PES_IDLE: next_st = take ? pes_pkg::PES_ACK : pes_pkg::PES_IDLE;
      pes_pkg::PES_ACK:  next_st = pes_pkg::PES_IDLE;
      default:           next_st = pes_pkg::PES_IDLE;
    endcase
  end

  // writes and read capture happen at the taking edge, so a clearing read and its
  // returned value refer to the same instant and no event slips between them
  always_comb begin
    next_enable = enable;
    next_ctrl   = ctrl;
    next_page   = page;
    next_rdat   = rdat;
    if (take && i_wb_we && i_wb_sel[0]) begin
      if (reg_hit(i_wb_adr, `PES_IDX_STAT)) begin
        next_enable = i_wb_dat[`PES_EVT_N-1:0];
      end
      if (reg_hit(i_wb_adr, `PES_IDX_CTRL)) begin
        next_ctrl = i_wb_dat[2:0];
      end
      if (reg_hit(i_wb_adr, `PES_IDX_PAGE)) begin
        next_page = i_wb_dat[`PES_PAGE_W-1:0];
      end
    end
    if (take && !i_wb_we) begin
      next_rdat = 32'h0000_0000; // unmapped reads return zero
      if (reg_hit(i_wb_adr, `PES_IDX_STAT)) begin
        next_rdat[`PES_PEND_LSB +: `PES_EVT_N] = evt_bus.pending;
        next_rdat[`PES_EVT_N-1:0]              = enable;
      end
      if (reg_hit(i_wb_adr, `PES_IDX_CTRL)) begin
        next_rdat[2:0] = ctrl;
      end
      if (reg_hit(i_wb_adr, `PES_IDX_PAGE)) begin
        next_rdat[`PES_PAGE_W-1:0] = page;
      end
    end
  end

  // register state
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st     <= pes_pkg::PES_IDLE;
      enable <= `PES_RST_EN;
      ctrl   <= `PES_RST_CTRL;
      page   <= `PES_RST_PAGE;
      rdat   <= 32'h0000_0000;
    end else begin
      st     <= next_st;
      enable <= next_enable;
      ctrl   <= next_ctrl;
      page   <= next_page;
      rdat   <= next_rdat;
    end
  end

  assign o_wb_ack = (st == pes_pkg::PES_ACK);
  assign o_wb_dat = rdat;

  // pending flags live in the latch; the read that returns them clears them
  assign evt_bus.evt = i_evt;
  assign evt_bus.clr = take & ~i_wb_we & reg_hit(i_wb_adr, `PES_IDX_STAT);

  pes_event_latch u_latch (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .evt_bus    (evt_bus)
  );

  // interrupt level from flip-flops only; without the global bit events stay silent
  // software still has to set that bit, enables alone do nothing
  assign irq_lvl = (ctrl[`PES_CTRL_GLOBAL_EVENT_IRQ_ENABLE] & |(evt_bus.pending & enable))
                 | ctrl[`PES_CTRL_FORCED_TEST_IRQ];
  assign o_irq   = irq_lvl;

  // pin sampler; first stage feeds only the second
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= i_pd_pin;
      pin_sync <= pin_meta;
    end
  end

  // pin is active low both ways; power-down is only honoured while it is an input
  assign o_pd_pin_oe = ctrl[`PES_CTRL_OE];
  assign o_pd_pin    = ~irq_lvl;
  assign o_powerdown = ~ctrl[`PES_CTRL_OE] & ~pin_sync;

  // page decode; the reserved value maps neither page
  assign o_page_sel  = page;
  assign o_page_ext  = (page == `PES_PAGE_EXT);
  assign o_page_diag = (page == `PES_PAGE_DIAG);

  property p_latch_without_enable;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_evt != '0 && enable == '0 && !evt_bus.clr) |=> (evt_bus.pending != '0);
  endproperty
  a_latch_without_enable: assert property (p_latch_without_enable) else $error("flag not latched");

  property p_global_off;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (!ctrl[`PES_CTRL_GLOBAL_EVENT_IRQ_ENABLE] && !ctrl[`PES_CTRL_FORCED_TEST_IRQ]) |-> !o_irq;
  endproperty
  a_global_off: assert property (p_global_off) else $error("interrupt with global enable off");

  property p_test_forces;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      ctrl[`PES_CTRL_FORCED_TEST_IRQ] |-> (o_irq && o_pd_pin == 1'b0);
  endproperty
  a_test_forces: assert property (p_test_forces) else $error("test bit did not force interrupt");

  property p_event_irq;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_evt[7] && enable[7] && ctrl[`PES_CTRL_GLOBAL_EVENT_IRQ_ENABLE] && !take) |=> o_irq;
  endproperty
  a_event_irq: assert property (p_event_irq) else $error("enabled event gave no interrupt");

  property p_pin_role;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_pd_pin_oe == ctrl[`PES_CTRL_OE]) && (!o_pd_pin_oe || !o_powerdown);
  endproperty
  a_pin_role: assert property (p_pin_role) else $error("shared pin role wrong");

  property p_page_upper_zero;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_wb_ack && !i_wb_we && reg_hit(i_wb_adr, `PES_IDX_PAGE))
        |-> (o_wb_dat[31:2] == 30'h0 && o_wb_dat[1:0] == page);
  endproperty
  a_page_upper_zero: assert property (p_page_upper_zero) else $error("page readback wrong");

  property p_irq_drops;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_wb_ack && !i_wb_we && reg_hit(i_wb_adr, `PES_IDX_STAT) && $past(i_evt) == '0
       && !ctrl[`PES_CTRL_FORCED_TEST_IRQ]) |-> !o_irq;
  endproperty
  a_irq_drops: assert property (p_irq_drops) else $error("interrupt held after clearing read");

  property p_enable_write;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (take && i_wb_we && i_wb_sel[0] && reg_hit(i_wb_adr, `PES_IDX_STAT))
        |=> (enable == $past(i_wb_dat[7:0])) ##1 (enable == $past(i_wb_dat[7:0], 2));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write not stored");

  property p_page_map;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_page_diag == (o_page_sel == 2'h2)) && !(o_page_ext && o_page_diag);
  endproperty
  a_page_map: assert property (p_page_map) else $error("page mapping wrong");

  // bus checks lean on the master holding its address until ack, as classic cycles require
  property p_ack_pulse;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

  property p_take_acked;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      take |=> o_wb_ack;
  endproperty
  a_take_acked: assert property (p_take_acked) else $error("taken request not acknowledged");

  property p_ctrl_write;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (take && i_wb_we && i_wb_sel[0] && reg_hit(i_wb_adr, `PES_IDX_CTRL))
        |=> (ctrl == $past(i_wb_dat[2:0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

  property p_page_write;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (take && i_wb_we && i_wb_sel[0] && reg_hit(i_wb_adr, `PES_IDX_PAGE))
        |=> (page == $past(i_wb_dat[1:0]));
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write not stored");

  property p_stat_readback;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_wb_ack && !i_wb_we && reg_hit(i_wb_adr, `PES_IDX_STAT))
        |-> (o_wb_dat[31:16] == 16'h0000 && o_wb_dat[7:0] == enable);
  endproperty
  a_stat_readback: assert property (p_stat_readback) else $error("enable readback wrong");

  property p_pending_readback;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_wb_ack && !i_wb_we && reg_hit(i_wb_adr, `PES_IDX_STAT))
        |-> (o_wb_dat[15:8] == $past(evt_bus.pending));
  endproperty
  a_pending_readback: assert property (p_pending_readback) else $error("pending readback wrong");

  property p_ctrl_readback;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_wb_ack && !i_wb_we && reg_hit(i_wb_adr, `PES_IDX_CTRL))
        |-> (o_wb_dat[31:3] == 29'h0 && o_wb_dat[2:0] == ctrl);
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong");

  property p_enabled_flag_irq;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (ctrl[`PES_CTRL_GLOBAL_EVENT_IRQ_ENABLE] && (evt_bus.pending & enable) != '0) |-> o_irq;
  endproperty
  a_enabled_flag_irq: assert property (p_enabled_flag_irq) else $error("enabled flag gave no interrupt");

  property p_irq_has_cause;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      o_irq |-> (ctrl[`PES_CTRL_FORCED_TEST_IRQ]
                 || (ctrl[`PES_CTRL_GLOBAL_EVENT_IRQ_ENABLE] && (evt_bus.pending & enable) != '0));
  endproperty
  a_irq_has_cause: assert property (p_irq_has_cause) else $error("interrupt without cause");

  property p_oe_drive;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      o_pd_pin_oe |-> (o_pd_pin == !o_irq);
  endproperty
  a_oe_drive: assert property (p_oe_drive) else $error("shared pin not driven from interrupt");

  // no disable here: the check is about what reset itself leaves behind
  property p_reset_clears;
    @(posedge i_core_clk)
      i_sys_rst |=> (enable == '0 && ctrl == '0 && page == '0);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset values wrong");

  property p_page_hold;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (page != $past(page)) |-> ($past(take) && $past(i_wb_we));
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page changed without a write");
endmodule

/* src/pes_consts.svh */
// constants for the event status and page select block
// assumes a 32-bit wishbone slave with byte addresses, one word per register
`ifndef PES_CONSTS_SVH
`define PES_CONSTS_SVH

// register indices; byte address is four times the index
`define PES_IDX_CTRL   6'h11
`define PES_IDX_STAT   6'h12
`define PES_IDX_PAGE   6'h13
`define PES_ADR_W      8
// status register fields
`define PES_PEND_LSB   8
`define PES_EVT_N      8
// global control register fields
`define PES_CTRL_OE    0
`define PES_CTRL_GLOBAL_EVENT_IRQ_ENABLE 1
`define PES_CTRL_FORCED_TEST_IRQ  2
// page select values
`define PES_PAGE_W     2
`define PES_PAGE_EXT   2'h0
`define PES_PAGE_RSVD  2'h1
`define PES_PAGE_DIAG  2'h2
// reset values
`define PES_RST_EN     8'h00
`define PES_RST_CTRL   3'h0
`define PES_RST_PAGE   2'h0

`endif

/* src/pes_pkg.sv */
// types shared by the event status block
// assumes pes_consts.svh is on the include path
`include "pes_consts.svh"
package pes_pkg;
  typedef logic [`PES_EVT_N-1:0] pes_evt_t;
  typedef enum logic {PES_IDLE, PES_ACK} pes_bus_state_t;
endpackage

/* src/pes_evt_if.sv */
// carrier between the register block and the pending-flag latch
// assumes one clock domain, driven by the top module
`timescale 1ns/1ps
interface pes_evt_if;
  pes_pkg::pes_evt_t evt;     // event pulses, bit 7 link quality .. bit 0 rx error
  logic              clr;     // clearing read of the status register
  pes_pkg::pes_evt_t pending; // latched flags
  modport ctl (output evt, output clr, input pending);
  modport lat (input evt, input clr, output pending);
endinterface

/* src/pes_event_latch.sv */
// sticky pending flags, one per event source, cleared by a status read
// assumes events and clear come from logic on the same clock
`timescale 1ns/1ps
`include "pes_consts.svh"
module pes_event_latch (
  input  wire logic i_core_clk, // core clock
  input  wire logic i_sys_rst,  // synchronous reset, high
  pes_evt_if.lat    evt_bus     // events in, flags out
);
  pes_pkg::pes_evt_t pend;
  pes_pkg::pes_evt_t next_pend;

  // set beats clear so an event in the reading cycle survives
  genvar g;
  generate
    for (g = 0; g < `PES_EVT_N; g++) begin : g_flag
      always_comb begin
        next_pend[g] = (pend[g] & ~evt_bus.clr) | evt_bus.evt[g];
      end
    end
  endgenerate

  // register the flags
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pend <= `PES_RST_EN;
    end else begin
      pend <= next_pend;
    end
  end

  assign evt_bus.pending = pend;

  property p_evt_kept;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (evt_bus.evt != '0) |=> ((pend & $past(evt_bus.evt)) == $past(evt_bus.evt));
  endproperty
  a_evt_kept: assert property (p_evt_kept) else $error("event lost from pending flags");

  property p_read_clears;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (evt_bus.clr && evt_bus.evt == '0) |=> (pend == '0);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flags not cleared by read");
endmodule

/* dv/pes_wb_master.sv */
// partner model: the station management host as a classic wishbone master
// assumes the bench calls xfer only after reset has been released
`timescale 1ns/1ps
module pes_wb_master (
  input  wire logic        i_core_clk, // core clock
  output logic             o_cyc,      // wishbone cycle
  output logic             o_stb,      // wishbone strobe
  output logic             o_we,       // wishbone write
  output logic [7:0]       o_adr,      // byte address
  output logic [3:0]       o_sel,      // byte lanes
  output logic [31:0]      o_dat,      // write data
  input  wire logic        i_ack,      // acknowledge
  input  wire logic [31:0] i_dat       // read data
);
  // idle bus at time zero
  initial begin
    {o_cyc, o_stb, o_we, o_sel, o_adr, o_dat} = '0;
  end

  // one classic cycle; the host never assumes a latency, it waits for ack
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_core_clk);
    {o_cyc, o_stb, o_we} <= {2'h3, w};
    o_adr <= a;
    o_dat <= d;
    o_sel <= 4'h1;
    do @(posedge i_core_clk); while (i_ack !== 1'b1);
    q = i_dat;
    {o_cyc, o_stb, o_we} <= 3'h0;
    // released lines must not keep showing the old value
    o_adr <= ~a;
    o_dat <= ~d;
  endtask
endmodule

/* dv/pes_top_tb.sv */
// self-checking bench for the event status, global control and page registers
// assumes the design sources and the wishbone partner model are compiled first
`timescale 1ns/1ps
module pes_top_tb;
  logic              clk, rst, cyc, stb, we, ack, irq, pd_drv, pd_oe, pd_o, pwdn, ext, diag;
  logic [7:0]        adr;
  logic [3:0]        sel;
  logic [31:0]       wdat, rdat, q;
  logic [1:0]        page;
  pes_pkg::pes_evt_t evt;
  int                n_mismatch, compares, cycles;
  // pin has a pull-up on the board; the bench drives it only while the block listens
  wire               pd_wire = pd_oe ? pd_o : pd_drv;

  pes_wb_master u_pes_wb_master (.i_core_clk(clk), .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr),
    .o_sel(sel), .o_dat(wdat), .i_ack(ack), .i_dat(rdat));
  pes_top u_pes_top (.i_core_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_evt(evt),
    .o_irq(irq), .i_pd_pin(pd_wire), .o_pd_pin(pd_o), .o_pd_pin_oe(pd_oe), .o_powerdown(pwdn),
    .o_page_sel(page), .o_page_ext(ext), .o_page_diag(diag));

  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] reg %h exp %h got %h", a, e, g);
    end
  endtask

  // pins: irq, oe, drive, powerdown, page[1:0], ext, diag; sampled mid-cycle
  task automatic chk_pin(input logic [7:0] e);
    @(negedge clk);
    compares++;
    if ({irq, pd_oe, pd_o, pwdn, page, ext, diag} !== e) begin
      n_mismatch++;
      $display("[FAIL] pins exp %h got %h", e, {irq, pd_oe, pd_o, pwdn, page, ext, diag});
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    u_pes_wb_master.xfer(1'b0, a, 32'h0, r);
    chk_reg(a, e, r);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_pes_wb_master.xfer(1'b1, a, d, q);
  endtask

  task automatic pulse(input logic [7:0] b);
    @(posedge clk);
    evt <= b;
    @(posedge clk);
    evt <= 8'h00;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard; the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    evt = 8'h00;
    pd_drv = 1'b1;
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    chk_pin(8'h22);
    rd(8'h48, 32'h0);
    rd(8'h4C, 32'h0);
    rd(8'h44, 32'h0);
    // every source latches with its enable off, and a read clears it
    for (int k = 0; k < 8; k++) begin
      pulse(8'h01 << k);
      chk_pin(8'h22);
      rd(8'h48, 32'h100 << k);
      rd(8'h48, 32'h0);
    end
    wr(8'h48, 32'hFFFF);
    rd(8'h48, 32'hFF);
    pulse(8'h20);
    chk_pin(8'h22);
    wr(8'h44, 32'h2);
    chk_pin(8'h82);
    rd(8'h48, 32'h20FF);
    chk_pin(8'h22);
    wr(8'h48, 32'hDF);
    pulse(8'h20);
    chk_pin(8'h22);
    pulse(8'h10);
    chk_pin(8'h82);
    rd(8'h48, 32'h30DF);
    // event landing on the clearing edge survives the read
    pulse(8'h40);
    fork
      rd(8'h48, 32'h40DF);
      pulse(8'h80);
    join
    rd(8'h48, 32'h80DF);
    pulse(8'h80);
    chk_pin(8'h82);
    rd(8'h48, 32'h80DF);
    wr(8'h44, 32'h1);
    chk_pin(8'h62);
    wr(8'h44, 32'h5);
    chk_pin(8'hC2);
    rd(8'h44, 32'h5);
    wr(8'h44, 32'h0);
    pd_drv <= 1'b0;
    repeat (4) @(posedge clk);
    chk_pin(8'h32);
    @(posedge clk);
    pd_drv <= 1'b1;
    wr(8'h4C, 32'hFFFF);
    rd(8'h4C, 32'h3);
    chk_pin(8'h2C);
    wr(8'h4C, 32'h2);
    chk_pin(8'h29);
    wr(8'h4C, 32'h1);
    chk_pin(8'h24);
    wr(8'h4C, 32'h0);
    chk_pin(8'h22);
    wr(8'h50, 32'hFFFF);
    rd(8'h50, 32'h0);
    wrap_up();
  end
endmodule
